/* core/rsfc_regs.sv */
// APB register bank: CRC-fail statistics, sync power results, FSK setup
// Behaviour
// - Count each frame passing header check but failing CRC, 32 bits.
// - Failed-frame counter is zero after reset.
// - Writing one to statistics clear zeroes counter; bit self-clears.
// - Fine sync power value feeds the receive level filter.
// - Both power results follow the selected receive save bank.
// - CCA uses link rate unless override set, then CCA fields apply.
// - OFDM option field bits 7:6 select options one to four.
// - Link rate code maps to listed rates; some codes prohibited.
// - CCA rate code uses the same mapping as link rate.
// - Modulation index bit selects 0.5 when clear, 1.0 when set.
// - Bit 0 enables receive FEC; bit 1 selects encoder type.
// - CRC width bit selects 32 or 16; auto ACK follows received frame.
// - Whitening applies to transmitted frames only while bit 3 set.
// - Bits 5 and 4 are sent as header bits 2 and 1.
// - Force-clear bit makes received mode-switch flag read as zero.
// - Separate receive and transmit bits pick GFSK or plain FSK.
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
module rsfc_regs
  import rsfc_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Receive frame status
  input wire logic crc_done_in,
  input wire logic crc_pass_in,
  input wire logic rx_frame_crc16_in,
  input wire logic ack_reply_in,
  input wire logic rx_mode_switch_in,
  // Sync power capture
  input wire logic sync_power_valid_in,
  input wire logic sync_power_bank_in,
  input wire logic [9:0] sync_power_fine_in,
  input wire logic [7:0] sync_power_coarse_in,
  input wire logic save_bank_sel_in,
  // Level filter
  output logic [9:0] sync_power_fine_out,
  // Rate and index controls
  output logic [11:0] link_rate_out,
  output logic link_rate_bad_out,
  output logic link_mod_index_sel_out,
  output logic [11:0] cca_rate_out,
  output logic cca_rate_bad_out,
  output logic cca_mod_index_out,
  output logic cca_rate_override_out,
  output logic [1:0] cca_ofdm_option_out,
  // Coding controls
  output logic rx_fec_enable_out,
  output logic encoder_type_sel_out,
  output logic tx_crc16_out,
  output logic whitening_enable_out,
  output logic tx_header_bit1_out,
  output logic tx_header_bit2_out,
  output logic interleave_enable_out,
  output logic rx_mode_switch_out,
  output logic rx_gauss_select_out,
  output logic tx_gauss_select_out
);
  logic [7:0] cca_reg;
  logic [4:0] fsk0_reg;
  logic [7:0] fsk1_reg;
  logic [1:0] fsk2_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [9:0] fine_bank_reg [RSFC_BANKS];
  logic [7:0] coarse_bank_reg [RSFC_BANKS];
  logic [31:0] crc_fail_count;
  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic wr_en;
  logic stats_clear;
  logic fail_event;
  logic [11:0] cca_own_rate;
  logic cca_own_bad;

  assign idx = paddr_in[11:2];
  assign aligned = (paddr_in[1:0] == 2'b00);
  assign setup = psel_in && !penable_in;
  // No wait state: read data is registered in setup, so ready follows enable
  assign pready_out = psel_in && penable_in;
  assign wr_en = pready_out && pwrite_in && !pslverr_reg && ce_in;

  assign stats_clear = wr_en && (idx == RSFC_IDX_STATS) && pwdata_in[RSFC_STATS_CLR];
  assign fail_event = crc_done_in && !crc_pass_in;

  rsfc_fail_counter u_fail_cnt (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .clear_in(stats_clear),
    .inc_in(fail_event),
    .count_out(crc_fail_count)
  );

  rsfc_rate_decode u_link_rate (
    .code_in(fsk0_reg[RSFC_FSK0_RATE_LSB +: 4]),
    .rate_out(link_rate_out),
    .bad_out(link_rate_bad_out)
  );

  // CCA rate uses the same table
  rsfc_rate_decode u_cca_rate (
    .code_in(cca_reg[RSFC_CCA_RATE_LSB +: 4]),
    .rate_out(cca_own_rate),
    .bad_out(cca_own_bad)
  );

  // Read mux; unmapped or misaligned addresses answer with an error
  always_comb
  begin
    prdata_next = 32'h00000000;
    pslverr_next = 1'b0;
    if (!aligned)
    begin
      pslverr_next = 1'b1;
    end
    else
    begin
      case (idx)
        RSFC_IDX_STATS: prdata_next = 32'h00000000;
        RSFC_IDX_CNT: prdata_next = crc_fail_count;
        RSFC_IDX_FINE: prdata_next = {22'h000000, sync_power_fine_out};
        RSFC_IDX_COARSE: prdata_next = {24'h000000, coarse_bank_reg[save_bank_sel_in]};
        RSFC_IDX_CCA: prdata_next = {24'h000000, cca_reg};
        RSFC_IDX_FSK0: prdata_next = {27'h0000000, fsk0_reg};
        RSFC_IDX_FSK1: prdata_next = {24'h000000, fsk1_reg};
        RSFC_IDX_FSK2: prdata_next = {30'h00000000, fsk2_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (ce_in && setup)
    begin
      prdata_reg <= pwrite_in ? 32'h00000000 : prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg && pready_out;

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      cca_reg <= RSFC_RST_CCA;
    end
    else if (wr_en && idx == RSFC_IDX_CCA)
    begin
      cca_reg <= pwdata_in[7:0];
    end
  end

  // Upper bits are not stored, so they always read as zero
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      fsk0_reg <= RSFC_RST_FSK0;
    end
    else if (wr_en && idx == RSFC_IDX_FSK0)
    begin
      fsk0_reg <= pwdata_in[4:0];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      fsk1_reg <= RSFC_RST_FSK1;
    end
    else if (wr_en && idx == RSFC_IDX_FSK1)
    begin
      fsk1_reg <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      fsk2_reg <= RSFC_RST_FSK2;
    end
    else if (wr_en && idx == RSFC_IDX_FSK2)
    begin
      fsk2_reg <= pwdata_in[1:0];
    end
  end

  // Per-bank capture of sync power results
  genvar b;
  generate
    for (b = 0; b < RSFC_BANKS; b++)
    begin : g_bank
      always_ff @(posedge mclk_in)
      begin
        if (!resetn_in)
        begin
          fine_bank_reg[b] <= RSFC_RST_FINE;
          coarse_bank_reg[b] <= RSFC_RST_COARSE;
        end
        else if (ce_in && sync_power_valid_in && (sync_power_bank_in == 1'(b)))
        begin
          fine_bank_reg[b] <= sync_power_fine_in;
          coarse_bank_reg[b] <= sync_power_coarse_in;
        end
      end
    end
  endgenerate

  // level filter sees the fine value of the selected bank
  assign sync_power_fine_out = fine_bank_reg[save_bank_sel_in];

  // link index bit, 0.5 when clear, 1.0 when set
  assign link_mod_index_sel_out = fsk0_reg[RSFC_FSK0_IDX];
  // CCA rate and index settings apply only under override
  assign cca_rate_override_out = cca_reg[RSFC_CCA_OVR];
  assign cca_rate_out = cca_rate_override_out ? cca_own_rate : link_rate_out;
  assign cca_rate_bad_out = cca_rate_override_out ? cca_own_bad : link_rate_bad_out;
  assign cca_mod_index_out = cca_rate_override_out ? cca_reg[RSFC_CCA_IDX]
                                                   : link_mod_index_sel_out;
  // option code 00 to 11 is option one to four
  assign cca_ofdm_option_out = cca_reg[RSFC_CCA_OPT_LSB +: 2];

  assign rx_fec_enable_out = fsk1_reg[RSFC_F1_FECRX];
  assign encoder_type_sel_out = fsk1_reg[RSFC_F1_ENC];
  // auto ACK reply reuses the received CRC width
  assign tx_crc16_out = ack_reply_in ? rx_frame_crc16_in : fsk1_reg[RSFC_F1_CRC16];
  assign whitening_enable_out = fsk1_reg[RSFC_F1_WHITE];
  assign tx_header_bit1_out = fsk1_reg[RSFC_F1_HB1];
  assign tx_header_bit2_out = fsk1_reg[RSFC_F1_HB2];
  // not enforced; software keeps it set for the non-recursive encoder
  assign interleave_enable_out = fsk1_reg[RSFC_F1_INTLV];
  // forced clear of received mode-switch flag
  assign rx_mode_switch_out = rx_mode_switch_in && !fsk1_reg[RSFC_F1_FORCE];
  assign rx_gauss_select_out = fsk2_reg[RSFC_F2_RX];
  assign tx_gauss_select_out = fsk2_reg[RSFC_F2_TX];

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_count_inc;
    ce_in && fail_event && !stats_clear && (crc_fail_count != 32'hFFFFFFFF)
      |=> crc_fail_count == $past(crc_fail_count) + 32'h00000001;
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("failed-frame counter did not advance");

  property p_count_hold;
    ce_in && !fail_event && !stats_clear |=> $stable(crc_fail_count);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("failed-frame counter moved without an event");

  property p_count_rst;
    $rose(resetn_in) |-> crc_fail_count == 32'h00000000;
  endproperty
  a_count_rst: assert property (p_count_rst)
    else $error("failed-frame counter not zero after reset");

  property p_count_clear;
    stats_clear && !fail_event |=> crc_fail_count == 32'h00000000;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("statistics clear did not zero the counter");

  property p_count_wrap;
    ce_in && fail_event && !stats_clear && (crc_fail_count == 32'hFFFFFFFF)
      |=> crc_fail_count == 32'h00000000;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("failed-frame counter did not wrap");

  property p_fine_bank;
    ce_in && sync_power_valid_in && (sync_power_bank_in == save_bank_sel_in)
      ##1 $stable(save_bank_sel_in) |-> sync_power_fine_out == $past(sync_power_fine_in);
  endproperty
  a_fine_bank: assert property (p_fine_bank)
    else $error("fine power does not follow the selected bank");

  property p_power_rst;
    $rose(resetn_in) |-> sync_power_fine_out == RSFC_RST_FINE
      && coarse_bank_reg[save_bank_sel_in] == RSFC_RST_COARSE;
  endproperty
  a_power_rst: assert property (p_power_rst)
    else $error("sync power results not at reset values");

  property p_cca_follow;
    !cca_rate_override_out |-> cca_rate_out == link_rate_out
      && cca_mod_index_out == link_mod_index_sel_out;
  endproperty
  a_cca_follow: assert property (p_cca_follow)
    else $error("CCA rate differs from link rate without override");

  property p_force_clear;
    fsk1_reg[RSFC_F1_FORCE] |-> !rx_mode_switch_out;
  endproperty
  a_force_clear: assert property (p_force_clear)
    else $error("mode-switch flag passed while forced clear");

  property p_ack_crc;
    ack_reply_in |-> tx_crc16_out == rx_frame_crc16_in;
  endproperty
  a_ack_crc: assert property (p_ack_crc)
    else $error("auto ACK CRC width not taken from received frame");

  property p_white_wr;
    wr_en && idx == RSFC_IDX_FSK1 |=> whitening_enable_out == $past(pwdata_in[3])
      && tx_header_bit2_out == $past(pwdata_in[5]);
  endproperty
  a_white_wr: assert property (p_white_wr)
    else $error("coding register write not reflected on controls");

  property p_ready;
    psel_in && !penable_in |=> !penable_in || pready_out;
  endproperty
  a_ready: assert property (p_ready)
    else $error("access phase not ready at once");
endmodule
`default_nettype wire

/* core/rsfc_pkg.sv */
// Shared constants for the receive statistics and FSK configuration bank
`default_nettype none
package rsfc_pkg;
  localparam int RSFC_AW = 12;
  localparam int RSFC_IW = 10;
  // Register indices; byte address is index times four
  localparam logic [9:0] RSFC_IDX_STATS = 10'h143;
  localparam logic [9:0] RSFC_IDX_CNT = 10'h150;
  localparam logic [9:0] RSFC_IDX_FINE = 10'h158;
  localparam logic [9:0] RSFC_IDX_COARSE = 10'h15A;
  localparam logic [9:0] RSFC_IDX_CCA = 10'h15E;
  localparam logic [9:0] RSFC_IDX_FSK0 = 10'h160;
  localparam logic [9:0] RSFC_IDX_FSK1 = 10'h161;
  localparam logic [9:0] RSFC_IDX_FSK2 = 10'h162;
  // Reset values
  localparam logic [31:0] RSFC_RST_CNT = 32'h00000000;
  localparam logic [9:0] RSFC_RST_FINE = 10'h200;
  localparam logic [7:0] RSFC_RST_COARSE = 8'h80;
  localparam logic [7:0] RSFC_RST_CCA = 8'h00;
  localparam logic [4:0] RSFC_RST_FSK0 = 5'h00;
  localparam logic [7:0] RSFC_RST_FSK1 = 8'h8C;
  localparam logic [1:0] RSFC_RST_FSK2 = 2'h0;
  // Field positions
  localparam int RSFC_STATS_CLR = 0;
  localparam int RSFC_CCA_OVR = 0;
  localparam int RSFC_CCA_IDX = 1;
  localparam int RSFC_CCA_RATE_LSB = 2;
  localparam int RSFC_CCA_OPT_LSB = 6;
  localparam int RSFC_FSK0_IDX = 0;
  localparam int RSFC_FSK0_RATE_LSB = 1;
  localparam int RSFC_F1_FECRX = 0;
  localparam int RSFC_F1_ENC = 1;
  localparam int RSFC_F1_CRC16 = 2;
  localparam int RSFC_F1_WHITE = 3;
  localparam int RSFC_F1_HB1 = 4;
  localparam int RSFC_F1_HB2 = 5;
  localparam int RSFC_F1_INTLV = 6;
  localparam int RSFC_F1_FORCE = 7;
  localparam int RSFC_F2_TX = 0;
  localparam int RSFC_F2_RX = 1;
  localparam int RSFC_BANKS = 2;
  // Rate per code in units of 100 bps; zero marks a prohibited code
  localparam logic [11:0] RSFC_RATE_TBL [16] = '{
    12'h1F4, 12'h3E8, 12'h5DC, 12'h7D0, 12'h064, 12'h0C8, 12'h000, 12'h000,
    12'h060, 12'h0C0, 12'h180, 12'h480, 12'h000, 12'h000, 12'h000, 12'h000};
endpackage
`default_nettype wire

/* core/rsfc_fail_counter.sv */
// Wrapping 32-bit counter of frames that failed CRC after a good header
`default_nettype none
module rsfc_fail_counter
  import rsfc_pkg::*;
(
  // Clock and control
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Events
  input wire logic clear_in,
  input wire logic inc_in,
  // Count
  output logic [31:0] count_out
);
  logic [31:0] count_reg;
  logic [31:0] count_next;

  // wraps to zero, one count per event
  // An event in the clearing cycle still counts once
  always_comb
  begin
    count_next = clear_in ? RSFC_RST_CNT : count_reg;
    if (inc_in)
    begin
      count_next = count_next + 32'h00000001;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      count_reg <= RSFC_RST_CNT;
    end
    else if (ce_in)
    begin
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;
endmodule
`default_nettype wire

/* core/rsfc_rate_decode.sv */
// Decodes a 4-bit FSK rate code into a rate and a prohibited flag
`default_nettype none
module rsfc_rate_decode
  import rsfc_pkg::*;
(
  // Code
  input wire logic [3:0] code_in,
  // Decoded rate, units of 100 bps
  output logic [11:0] rate_out,
  output logic bad_out
);
  assign rate_out = RSFC_RATE_TBL[code_in];
  assign bad_out = (rate_out == 12'h000);
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the statistics and FSK configuration register bank
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) \
    begin \
      err_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module tb_top
  import rsfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, resetn_in, ce_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out;
  logic crc_done_in, crc_pass_in, rx_frame_crc16_in, ack_reply_in, rx_mode_switch_in;
  logic sync_power_valid_in, sync_power_bank_in, save_bank_sel_in;
  logic [9:0] sync_power_fine_in, sync_power_fine_out;
  logic [7:0] sync_power_coarse_in;
  logic [11:0] link_rate_out, cca_rate_out;
  logic link_rate_bad_out, link_mod_index_sel_out, cca_rate_bad_out, cca_mod_index_out;
  logic cca_rate_override_out, rx_fec_enable_out, encoder_type_sel_out, tx_crc16_out;
  logic [1:0] cca_ofdm_option_out;
  logic whitening_enable_out, tx_header_bit1_out, tx_header_bit2_out, interleave_enable_out;
  logic rx_mode_switch_out, rx_gauss_select_out, tx_gauss_select_out;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] d;
  logic [31:0] cv;
  logic e;
  // Expected rates, 100 bps units; zero marks a prohibited code
  logic [11:0] rate_t [16] = '{12'h1F4, 12'h3E8, 12'h5DC, 12'h7D0, 12'h064, 12'h0C8, 12'h000,
    12'h000, 12'h060, 12'h0C0, 12'h180, 12'h480, 12'h000, 12'h000, 12'h000, 12'h000};
  logic [9:0] idx_t [8] = '{RSFC_IDX_STATS, RSFC_IDX_CNT, RSFC_IDX_FINE, RSFC_IDX_COARSE,
    RSFC_IDX_CCA, RSFC_IDX_FSK0, RSFC_IDX_FSK1, RSFC_IDX_FSK2};
  logic [31:0] rst_t [8] = '{32'h0, 32'h0, 32'h200, 32'h80, 32'h0, 32'h0, 32'h8C, 32'h0};
  logic [9:0] fine_t [2] = '{10'h33D, 10'h05A};
  logic [7:0] coarse_t [2] = '{8'h9E, 8'h21};

  rsfc_regs u_rsfc_regs (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .crc_done_in(crc_done_in), .crc_pass_in(crc_pass_in),
    .rx_frame_crc16_in(rx_frame_crc16_in), .ack_reply_in(ack_reply_in),
    .rx_mode_switch_in(rx_mode_switch_in), .sync_power_valid_in(sync_power_valid_in),
    .sync_power_bank_in(sync_power_bank_in), .sync_power_fine_in(sync_power_fine_in),
    .sync_power_coarse_in(sync_power_coarse_in), .save_bank_sel_in(save_bank_sel_in),
    .sync_power_fine_out(sync_power_fine_out), .link_rate_out(link_rate_out),
    .link_rate_bad_out(link_rate_bad_out), .link_mod_index_sel_out(link_mod_index_sel_out),
    .cca_rate_out(cca_rate_out), .cca_rate_bad_out(cca_rate_bad_out),
    .cca_mod_index_out(cca_mod_index_out), .cca_rate_override_out(cca_rate_override_out),
    .cca_ofdm_option_out(cca_ofdm_option_out), .rx_fec_enable_out(rx_fec_enable_out),
    .encoder_type_sel_out(encoder_type_sel_out), .tx_crc16_out(tx_crc16_out),
    .whitening_enable_out(whitening_enable_out), .tx_header_bit1_out(tx_header_bit1_out),
    .tx_header_bit2_out(tx_header_bit2_out), .interleave_enable_out(interleave_enable_out),
    .rx_mode_switch_out(rx_mode_switch_out), .rx_gauss_select_out(rx_gauss_select_out),
    .tx_gauss_select_out(tx_gauss_select_out));

  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do
    begin
      @(posedge mclk_in);
    end
    while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] v);
    apb(1'b1, ba(i), v, d, e);
    @(negedge mclk_in);
  endtask

  task automatic chk_rd(input logic [9:0] i, input logic [31:0] v, input string nm);
    apb(1'b0, ba(i), 32'h0, d, e);
    `CHK(nm, {1'b0, v}, {e, d})
  endtask

  // Held high for n edges, so frames arrive back to back
  task automatic frames(input int n, input logic pass);
    @(posedge mclk_in);
    crc_done_in <= 1'b1;
    crc_pass_in <= pass;
    repeat (n) @(posedge mclk_in);
    crc_done_in <= 1'b0;
  endtask

  task automatic cap(input logic b, input logic [9:0] f, input logic [7:0] c);
    @(posedge mclk_in);
    sync_power_valid_in <= 1'b1;
    sync_power_bank_in <= b;
    sync_power_fine_in <= f;
    sync_power_coarse_in <= c;
    @(posedge mclk_in);
    sync_power_valid_in <= 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    {resetn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {crc_done_in, crc_pass_in, rx_frame_crc16_in, ack_reply_in, rx_mode_switch_in} = '0;
    {sync_power_valid_in, sync_power_bank_in, sync_power_fine_in} = '0;
    {sync_power_coarse_in, save_bank_sel_in} = '0;
    ce_in = 1'b1;
    repeat (5) @(posedge mclk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++)
      chk_rd(idx_t[i], rst_t[i], "reset value"); // reset values
    `CHK("fine out reset", 10'h200, sync_power_fine_out) // reset value
    apb(1'b0, 12'hFFC, 32'h0, d, e);
    `CHK("unmapped read", 33'h100000000, {e, d})
    apb(1'b0, ba(RSFC_IDX_CNT) + 12'h1, 32'h0, d, e);
    `CHK("misaligned read", 33'h100000000, {e, d})
    wr(RSFC_IDX_CNT, 32'h5);
    frames(3, 1'b0);
    frames(2, 1'b1);
    chk_rd(RSFC_IDX_CNT, 32'h3, "fail count"); // fails only
    wr(RSFC_IDX_STATS, 32'h1);
    chk_rd(RSFC_IDX_CNT, 32'h0, "cleared count"); // clear
    chk_rd(RSFC_IDX_STATS, 32'h0, "clear bit"); // self clear
    frames(1, 1'b0);
    chk_rd(RSFC_IDX_CNT, 32'h1, "count after clear"); // counts on
    frames(255, 1'b0);
    apb(1'b0, ba(RSFC_IDX_CNT), 32'h0, d, e);
    `CHK("count carry", 32'h100, d) // carry into second byte
    if (d[7:0] == 8'h00)
      chk_rd(RSFC_IDX_CNT, 32'h100, "reread count"); // low byte 00H read again
    ce_in <= 1'b0;
    frames(2, 1'b0);
    ce_in <= 1'b1;
    chk_rd(RSFC_IDX_CNT, 32'h100, "frozen count"); // no count while disabled
    cap(1'b0, fine_t[0], coarse_t[0]);
    cap(1'b1, fine_t[1], coarse_t[1]);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge mclk_in);
      save_bank_sel_in <= b[0];
      chk_rd(RSFC_IDX_FINE, {22'h0, fine_t[b]}, "fine bank"); // fine
      chk_rd(RSFC_IDX_COARSE, {24'h0, coarse_t[b]}, "coarse bank"); // coarse
      `CHK("fine out", fine_t[b], sync_power_fine_out) // filter value
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(RSFC_IDX_FSK0, {27'h0, i[3:0], i[0]}); // upper bits zero
      wr(RSFC_IDX_CCA, {24'h0, i[1:0], 4'hF - i[3:0], ~i[0], 1'b1});
      `CHK("link rate", {rate_t[i], rate_t[i] == 12'h0}, {link_rate_out, link_rate_bad_out})
      `CHK("link index", i[0], link_mod_index_sel_out) // link index
      `CHK("cca rate", {rate_t[15 - i], rate_t[15 - i] == 12'h0}, {cca_rate_out, cca_rate_bad_out})
      `CHK("cca fields", {i[1:0], ~i[0], 1'b1}, {cca_ofdm_option_out, cca_mod_index_out,
        cca_rate_override_out})
      chk_rd(RSFC_IDX_FSK0, {27'h0, i[3:0], i[0]}, "rate readback"); // readback
    end
    wr(RSFC_IDX_CCA, 32'hA0);
    `CHK("cca follows link", {rate_t[15], 1'b1, 1'b1}, {cca_rate_out, cca_rate_bad_out,
      cca_mod_index_out}) // override off
    @(posedge mclk_in);
    rx_mode_switch_in <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      cv = (32'h1 << k) | ((k == 1) ? 32'h0 : 32'h40);
      wr(RSFC_IDX_FSK1, cv); // interleave kept on with NRNSC
      `CHK("coding bits", {cv[7:0]}, {~rx_mode_switch_out, interleave_enable_out,
        tx_header_bit2_out, tx_header_bit1_out, whitening_enable_out, tx_crc16_out,
        encoder_type_sel_out, rx_fec_enable_out})
      chk_rd(RSFC_IDX_FSK1, cv, "coding readback"); // readback
    end
    ack_reply_in <= 1'b1;
    rx_frame_crc16_in <= 1'b1;
    @(negedge mclk_in);
    `CHK("ack crc16", 1'b1, tx_crc16_out) // ack uses received width
    wr(RSFC_IDX_FSK1, 32'h44); // interleave kept on with NRNSC
    @(posedge mclk_in);
    rx_frame_crc16_in <= 1'b0;
    @(negedge mclk_in);
    `CHK("ack crc32", 1'b0, tx_crc16_out) // ack ignores width bit
    for (int m = 1; m < 4; m++)
    begin
      wr(RSFC_IDX_FSK2, m);
      `CHK("gauss select", m[1:0], {rx_gauss_select_out, tx_gauss_select_out})
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
